// File: core/rx_page_pkg.sv
// package: constants and carriers for the receive-port register paging block
// assumes an 8-bit register access port fed by the device's i2c and control-channel front ends
package rx_page_pkg;
	localparam int num_ports = 2;
	localparam int num_sources = 3;
	// register offsets
	localparam logic [7:0] link_capability_addr = 8'h4a;
	localparam logic [7:0] embedded_type_control_addr = 8'h4b;
	localparam logic [7:0] receive_port_page_select_addr = 8'h4c;
	localparam logic [7:0] paged_lo_start = 8'h4d;
	localparam logic [7:0] paged_lo_end = 8'h7f;
	localparam logic [7:0] paged_hi_start = 8'hd0;
	localparam logic [7:0] paged_hi_end = 8'hdf;
	// field positions
	localparam int write_port0_bit = 0;
	localparam int write_port1_bit = 1;
	localparam int read_port_bit = 4;
	localparam int physical_link_index_bit = 6;
	localparam int encoder_crc_flag_enable_bit = 4;
	localparam int embedded_line_count_lsb = 6;
	localparam int embedded_type_value_lsb = 0;
	// reset values
	localparam logic [7:0] link_capability_reset = 8'h00;
	localparam logic [7:0] embedded_type_control_reset = 8'h12;
	// access source: 0 local i2c, 1 control channel of port 0, 2 control channel of port 1
	localparam logic [1:0] source_local = 2'h0;
	// page select reset per source, lowest bit or pair for the local context
	localparam logic [2:0] read_select_reset = 3'h4;
	localparam logic [5:0] write_enable_reset = 6'h24;

	typedef struct packed {
		logic valid;
		logic write;
		logic [1:0] source;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic sof;
		logic long_pkt;
		logic raw_mode;
		logic [5:0] raw_type;
	} pkt_info_s;
endpackage : rx_page_pkg

// File: core/rx_port_copy.sv
// one receive port's copy of the paged registers, with the data-type substitution it steers
// assumes the parent decodes paged addresses and gates the write strobe per port
`timescale 1ns/10ps
module rx_port_copy (
	input wire logic clk, // register clock
	input wire logic rst_n, // synchronous reset, active low
	input wire logic we, // write strobe for this copy
	input wire logic [7:0] addr, // register offset
	input wire logic [7:0] wdata, // write data
	output logic [7:0] rdata, // registered read data of the addressed register
	output logic crc_flag_enable, // encoder crc flag gate
	input wire rx_page_pkg::pkt_info_s pkt, // packet stream info for this port
	output logic [5:0] type_out // data type to forward, registered
);
	import rx_page_pkg::*;

	logic [7:0] cap_q, cap_d;
	logic [7:0] emb_q, emb_d;
	logic [1:0] lines_q, lines_d;
	logic [7:0] rdata_d;
	logic [5:0] type_d;
	logic [1:0] count;

	always_comb begin
		cap_d = cap_q;
		emb_d = emb_q;
		if (we && addr == link_capability_addr) begin
			cap_d = wdata;
		end
		if (we && addr == embedded_type_control_addr) begin
			emb_d = wdata;
		end
		unique case (addr)
			link_capability_addr: rdata_d = cap_q;
			embedded_type_control_addr: rdata_d = emb_q;
			default: rdata_d = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	assign count = emb_q[embedded_line_count_lsb +: 2];

	always_comb begin
		lines_d = lines_q;
		type_d = type_out;
		if (pkt.long_pkt) begin
			// the sof packet itself counts as line one of the frame
			if (pkt.raw_mode && count != 2'h0 && (pkt.sof ? 2'h0 : lines_q) < count) begin
				type_d = emb_q[embedded_type_value_lsb +: 6];
			end else begin
				type_d = pkt.raw_type;
			end
			if (pkt.sof) begin
				lines_d = 2'h1;
			end else if (lines_q != 2'h3) begin
				lines_d = lines_q + 2'h1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cap_q <= link_capability_reset;
			emb_q <= embedded_type_control_reset;
			lines_q <= 2'h0;
			rdata <= 8'h00;
			type_out <= 6'h00;
		end else begin
			cap_q <= cap_d;
			emb_q <= emb_d;
			lines_q <= lines_d;
			rdata <= rdata_d;
			type_out <= type_d;
		end
	end

	assign crc_flag_enable = cap_q[encoder_crc_flag_enable_bit];
endmodule : rx_port_copy

// File: core/rx_port_register_paging.sv
// receive-port register paging: per-source page select and two per-port register copies
// assumes the i2c and control-channel front ends deliver one-cycle access strobes on clk
//
// Summary of operation
// - accesses to 0x4a, 0x4b, 0x4d-0x7f, 0xd0-0xdf go through the page select.
// - bit 4 picks which port copy answers paged reads.
// - bits 0 and 1 enable writes per port; both set broadcasts.
// - each access source keeps its own page select context.
// - bit 6 reads 0 locally, else the port the access came on.
// - read select defaults 0 locally, else to the arriving port.
// - write enables reset 0, except own port's bit in its channel context.
// - capability bit 4 gates the encoder crc flag; resets to 0.
// - raw mode with line count 00 forwards all packets as raw type.
// - line count 1 to 3 sends that many first packets as embedded.
// - six-bit embedded type, reset 0x12, replaces the raw type.
// - substitution has no effect in csi-2 receive mode.
`timescale 1ns/10ps
module rx_port_register_paging (
	input wire logic clk, // register clock, 25 MHz
	input wire logic rst_n, // synchronous reset, active low
	input wire rx_page_pkg::reg_req_s req, // register access request
	output logic ack, // access accepted
	output logic [7:0] rdata, // read data, valid the cycle after ack
	output logic rdata_valid, // read data valid strobe
	input wire logic [1:0] encoder_crc_error, // raw crc error flag per port
	output logic [1:0] encoder_crc_flag, // gated crc error flag per port
	input wire rx_page_pkg::pkt_info_s pkt0, // packet info, port 0
	input wire rx_page_pkg::pkt_info_s pkt1, // packet info, port 1
	output logic [5:0] type_out0, // forwarded data type, port 0
	output logic [5:0] type_out1 // forwarded data type, port 1
);
	import rx_page_pkg::*;

	function automatic logic is_paged(input logic [7:0] a);
		return a == link_capability_addr || a == embedded_type_control_addr ||
			(a >= paged_lo_start && a <= paged_lo_end) ||
			(a >= paged_hi_start && a <= paged_hi_end);
	endfunction : is_paged

	function automatic logic phys_index(input logic [1:0] src);
		return src == 2'h2;
	endfunction : phys_index

	////////////////////////////////////////////////////////////////////////
	// page context per source
	logic [num_sources-1:0] rd_sel_q, rd_sel_d;
	logic [1:0] wr_en_q [num_sources];
	logic [1:0] wr_en_d [num_sources];
	logic [1:0] src;
	logic sel_write;
	logic paged;

	assign src = req.source;
	assign sel_write = req.valid && req.write && req.addr == receive_port_page_select_addr;
	assign paged = is_paged(req.addr);

	always_comb begin
		rd_sel_d = rd_sel_q;
		for (int s = 0; s < num_sources; s++) begin
			wr_en_d[s] = wr_en_q[s];
		end
		if (sel_write) begin
			// only the requesting source's context moves
			rd_sel_d[src] = req.wdata[read_port_bit];
			wr_en_d[src] = {req.wdata[write_port1_bit], req.wdata[write_port0_bit]};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_sel_q <= read_select_reset;
			for (int s = 0; s < num_sources; s++) begin
				wr_en_q[s] <= write_enable_reset[2*s +: 2];
			end
		end else begin
			rd_sel_q <= rd_sel_d;
			for (int s = 0; s < num_sources; s++) begin
				wr_en_q[s] <= wr_en_d[s];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// port copies
	logic [7:0] copy_rdata [num_ports];
	logic [num_ports-1:0] crc_en;
	logic [num_ports-1:0] copy_we;
	pkt_info_s pkt [num_ports];
	logic [5:0] type_o [num_ports];

	assign pkt[0] = pkt0;
	assign pkt[1] = pkt1;
	assign type_out0 = type_o[0];
	assign type_out1 = type_o[1];

	generate
		for (genvar p = 0; p < num_ports; p++) begin : g_port
			// no enable in the context means the write is dropped, still acked
			assign copy_we[p] = req.valid && req.write && paged && wr_en_q[src][p];
			rx_port_copy u_copy (
				.clk(clk),
				.rst_n(rst_n),
				.we(copy_we[p]),
				.addr(req.addr),
				.wdata(req.wdata),
				.rdata(copy_rdata[p]),
				.crc_flag_enable(crc_en[p]),
				.pkt(pkt[p]),
				.type_out(type_o[p])
			);
		end
	endgenerate

	assign encoder_crc_flag = encoder_crc_error & crc_en;

	////////////////////////////////////////////////////////////////////////
	// read return; copies register their data, so selection is pipelined to match
	logic rd_pend_q, rd_pend_d;
	logic rd_paged_q, rd_paged_d;
	logic rd_port_q, rd_port_d;
	logic [7:0] sel_q, sel_d;

	assign ack = req.valid;

	always_comb begin
		rd_pend_d = req.valid && !req.write;
		rd_paged_d = paged;
		rd_port_d = rd_sel_q[src];
		sel_d = 8'h00;
		if (req.addr == receive_port_page_select_addr) begin
			sel_d[physical_link_index_bit] = phys_index(src);
			sel_d[read_port_bit] = rd_sel_q[src];
			sel_d[write_port1_bit] = wr_en_q[src][1];
			sel_d[write_port0_bit] = wr_en_q[src][0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rd_pend_q <= 1'b0;
			rd_paged_q <= 1'b0;
			rd_port_q <= 1'b0;
			sel_q <= 8'h00;
		end else begin
			rd_pend_q <= rd_pend_d;
			rd_paged_q <= rd_paged_d;
			rd_port_q <= rd_port_d;
			sel_q <= sel_d;
		end
	end

	assign rdata_valid = rd_pend_q;
	assign rdata = rd_paged_q ? copy_rdata[rd_port_q] : sel_q;
endmodule : rx_port_register_paging

// File: tb/rx_page_props.sv
// checker: port-level properties of the register paging block
// assumes it is bound onto rx_port_register_paging, one clock domain
`timescale 1ns/10ps
module rx_page_props (
	input wire logic clk, // clock
	input wire logic rst_n, // reset
	input wire rx_page_pkg::reg_req_s req, // request
	input wire logic ack, // ack
	input wire logic [7:0] rdata, // read data
	input wire logic rdata_valid, // read strobe
	input wire logic [1:0] encoder_crc_error, // raw crc
	input wire logic [1:0] encoder_crc_flag, // gated crc
	input wire rx_page_pkg::pkt_info_s pkt0, // port 0 pkt
	input wire rx_page_pkg::pkt_info_s pkt1, // port 1 pkt
	input wire logic [5:0] type_out0, // port 0 type
	input wire logic [5:0] type_out1 // port 1 type
);
	import rx_page_pkg::*;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_read;
		req.valid && !req.write;
	endsequence
	sequence s_sel_read;
		s_read ##0 req.addr == receive_port_page_select_addr;
	endsequence
	//////////////////////////////////////////////////////////////////////
	a_ack_every: assert property (ack == req.valid)
		else $error("ack mismatch");
	a_read_answer: assert property (s_read |=> rdata_valid)
		else $error("read not answered");
	a_no_stray: assert property (rdata_valid |-> $past(req.valid && !req.write))
		else $error("stray read strobe");
	a_crc_masked: assert property ((encoder_crc_flag & ~encoder_crc_error) == 2'h0)
		else $error("crc flag without error");
	a_crc_reset: assert property ($rose(rst_n) |-> encoder_crc_flag == 2'h0)
		else $error("crc flag set after reset");
	a_phys_index: assert property (s_sel_read |=> rdata[6] == ($past(req.source) == 2'h2))
		else $error("wrong physical index");
	a_csi_pass0: assert property (pkt0.long_pkt && !pkt0.raw_mode |=> type_out0 == $past(pkt0.raw_type))
		else $error("port 0 csi type altered");
	a_csi_pass1: assert property (pkt1.long_pkt && !pkt1.raw_mode |=> type_out1 == $past(pkt1.raw_type))
		else $error("port 1 csi type altered");
endmodule : rx_page_props
bind rx_port_register_paging rx_page_props u_props (.*);

// File: tb/i2c_host_model.sv
// partner: register host, local or over a control channel
// assumes ack in the request cycle and read data one cycle later
`timescale 1ns/10ps
module i2c_host_model (
	input wire logic clk, // clock
	output rx_page_pkg::reg_req_s req, // request
	input wire logic ack, // ack
	input wire logic [7:0] rdata, // read data
	input wire logic rdata_valid // read strobe
);
	import rx_page_pkg::*;
	logic [7:0] last_rd;
	logic last_ack;
	logic last_rdv;
	initial req = '0;
	task automatic access(input logic [1:0] src, input logic wr, input logic [7:0] addr, input logic [7:0] wd);
		@(posedge clk);
		req <= '{1'b1, wr, src, addr, wd};
		@(posedge clk);
		last_ack = ack;
		req.valid <= 1'b0;
		// released address and data lines flip so stale values never pass as live
		req.addr <= ~addr;
		req.wdata <= ~wd;
		#1;
		last_rdv = rdata_valid;
		last_rd = rdata;
	endtask : access
	task automatic crc_setup();
		access(source_local, 1'b1, receive_port_page_select_addr, 8'h03);
		access(source_local, 1'b1, link_capability_addr, 8'h10);
	endtask : crc_setup
endmodule : i2c_host_model

// File: tb/tb_rx_port_register_paging.sv
// testbench: context defaults, paging, broadcast, type substitution
// assumes design under core/, host model and checker under tb/
`timescale 1ns/10ps
module tb_rx_port_register_paging;
	import rx_page_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic ack, rdata_valid;
	logic [7:0] rdata;
	logic [1:0] encoder_crc_error = 2'h3;
	logic [1:0] encoder_crc_flag;
	reg_req_s req;
	pkt_info_s pkt0 = '0, pkt1 = '0;
	logic [5:0] type_out0, type_out1;
	int n_checks = 0;
	int n_mismatch = 0;
	always #20 clk = ~clk;
	rx_port_register_paging DUT (.*);
	i2c_host_model host (.*);
	//////////////////////////////////////////////////////////////////////
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic rd(input logic [1:0] src, input logic [7:0] addr, input logic [7:0] exp);
		host.access(src, 1'b0, addr, 8'h00);
		check("ack", {7'h0, host.last_ack}, 8'h01);
		check("strobe", {7'h0, host.last_rdv}, 8'h01);
		check("rdata", host.last_rd, exp);
	endtask : rd
	task automatic wr(input logic [1:0] src, input logic [7:0] addr, input logic [7:0] wd);
		host.access(src, 1'b1, addr, wd);
		check("ack", {7'h0, host.last_ack}, 8'h01);
	endtask : wr
	task automatic pk(input logic p, input logic sof, input logic raw, input logic [5:0] exp);
		@(posedge clk);
		if (p) pkt1 <= '{sof, 1'b1, raw, 6'h2a};
		else pkt0 <= '{sof, 1'b1, raw, 6'h2a};
		@(posedge clk);
		pkt0 <= '{1'b0, 1'b0, raw, 6'h15};
		pkt1 <= '{1'b0, 1'b0, raw, 6'h15};
		#1;
		check("type", {2'h0, p ? type_out1 : type_out0}, {2'h0, exp});
	endtask : pk
	//////////////////////////////////////////////////////////////////////
	task automatic t_defaults();
		rd(source_local, embedded_type_control_addr, 8'h12);
		rd(source_local, link_capability_addr, 8'h00);
		rd(2'h0, receive_port_page_select_addr, 8'h00);
		rd(2'h1, receive_port_page_select_addr, 8'h01);
		rd(2'h2, receive_port_page_select_addr, 8'h52);
		check("crc", {6'h0, encoder_crc_flag}, 8'h00);
	endtask : t_defaults
	task automatic t_paging();
		@(posedge clk) encoder_crc_error <= 2'h3;
		host.crc_setup();
		check("crc", {6'h0, encoder_crc_flag}, 8'h03);
		rd(2'h1, receive_port_page_select_addr, 8'h01);
		wr(2'h1, link_capability_addr, 8'h00);
		check("crc", {6'h0, encoder_crc_flag}, 8'h02);
		rd(2'h2, link_capability_addr, 8'h10);
		rd(2'h1, link_capability_addr, 8'h00);
		wr(source_local, receive_port_page_select_addr, 8'hff);
		rd(source_local, receive_port_page_select_addr, 8'h13);
		rd(source_local, link_capability_addr, 8'h10);
		wr(source_local, receive_port_page_select_addr, 8'h00);
		wr(source_local, link_capability_addr, 8'h08);
		rd(source_local, link_capability_addr, 8'h00);
		wr(source_local, receive_port_page_select_addr, 8'h10);
		rd(source_local, link_capability_addr, 8'h10);
	endtask : t_paging
	task automatic t_embed();
		wr(source_local, receive_port_page_select_addr, 8'h01);
		for (int n = 0; n < 4; n++) begin
			wr(source_local, embedded_type_control_addr, {n[1:0], 6'h2b});
			for (int i = 0; i < 5; i++)
				pk(1'b0, i == 0, 1'b1, i < n ? 6'h2b : 6'h2a);
		end
		pk(1'b0, 1'b1, 1'b0, 6'h2a);
		pk(1'b1, 1'b1, 1'b1, 6'h2a);
		pk(1'b1, 1'b1, 1'b0, 6'h2a);
	endtask : t_embed
	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : stop_test
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		t_defaults();
		t_paging();
		t_embed();
		stop_test();
	end
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		stop_test();
	end
endmodule : tb_rx_port_register_paging
